// file: verilog/idc_pkg.sv
// constants for the interrupt discovery and configuration capability block
// assumes a 32-bit configuration port with byte offsets 00h and 04h
`default_nettype none
package idc_pkg;
  localparam logic [7:0]  CAP_ENTRY_ID   = 8'h08;
  localparam logic [7:0]  CAP_TYPE_CODE  = 8'h80;
  localparam logic [7:0]  OFS_HEADER     = 8'h00;
  localparam logic [7:0]  OFS_DATAPORT   = 8'h04;
  localparam logic [7:0]  IDX_LAST_IRQ   = 8'h01;
  localparam logic [7:0]  IDX_DEF_BASE   = 8'h10;
  localparam logic [3:0]  BE_FULL_DW     = 4'hF;
  localparam int          BE_INDEX_LANE  = 2;
  localparam int          HDR_ID_LSB     = 0;
  localparam int          HDR_PTR_LSB    = 8;
  localparam int          HDR_IDX_LSB    = 16;
  localparam int          HDR_TYPE_LSB   = 24;
  localparam int          LAST_IRQ_LSB   = 16;
  // definition register field positions
  localparam int          B_WAIT_EOI     = 63;
  localparam int          B_PASSPW       = 62;
  localparam int          INFO_HI        = 55;
  localparam int          INFO_LO        = 2;
  localparam int          INFO_W         = INFO_HI - INFO_LO + 1;
  localparam int          B_RQ_EOI       = 5;
  localparam int          B_POLARITY     = 1;
  localparam int          B_MASK         = 0;
  localparam int          UPPER_LSB      = 32;
  localparam logic [63:0] DEF_RESET      = 64'h0000_0000_F800_0001;
  // writable bits apart from passpw and polarity, which depend on build options
  localparam logic [63:0] DEF_WMASK_BASE = 64'h00FF_FFFF_FFFF_FFFD;
endpackage : idc_pkg
`default_nettype wire

// file: verilog/idc_block.sv
// interrupt discovery and configuration capability with message issue logic
// assumes a single-cycle configuration port, synchronous source inputs and an
// upstream message sink that accepts with valid/ready
//
// Contract
// [RULE_01] header low byte reads fixed 08h
// [RULE_02] header bits 15:8 read the next entry pointer, 00h if last
// [RULE_03] header bits 31:24 read fixed 80h
// [RULE_04] writable index byte selects the register behind the dataport
// [RULE_05] software uses only whole doubleword dataport accesses
// [RULE_06] unassigned indexes read zero and ignore writes
// [RULE_07] index 01h reads the highest interrupt number in bits 23:16
// [RULE_08] interrupt n lives at indexes 10h+2n and 10h+2n+1
// [RULE_09] even index maps bits 31:0, odd index bits 63:32
// [RULE_10] with end-of-interrupt requested, send sets waiting; returned eoi clears it
// [RULE_11] software writing one to bit 63 clears waiting
// [RULE_12] bit 62 set sends messages with passpw set
// [RULE_13] bit 62 clear sends passpw clear and waits behind queued posted writes
// [RULE_14] single-behaviour build makes bit 62 read-only
// [RULE_15] info bits 31:24 writable, reset to F8h
// [RULE_16] software never writes F9h or above into bits 31:24
// [RULE_17] while waiting with eoi requested, the source sends nothing more
// [RULE_18] bits 4:2 hold a writable message type
// [RULE_19] polarity bit inverts external inputs; reserved for internal sources
// [RULE_20] mask resets to one and blocks all messages from the source
// [RULE_21] warm reset restores every definition field
// [RULE_22] an unmasked source going active sends one message carrying bits 55:2
`timescale 1ns/100ps
`default_nettype none
module idc_block #(
  parameter int                 NUM_IRQ    = 4,
  parameter logic [7:0]         NEXT_PTR   = 8'h00,
  parameter logic [NUM_IRQ-1:0] EXT_SRC    = '1,
  parameter bit                 PASSPW_RO  = 1'b0,
  parameter bit                 PASSPW_VAL = 1'b0,
  parameter int                 SW         = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_srst,
  input  wire logic [7:0]                  i_cfg_addr,
  input  wire logic                        i_cfg_wr,
  input  wire logic                        i_cfg_rd,
  input  wire logic [3:0]                  i_cfg_be,
  input  wire logic [31:0]                 i_cfg_wdata,
  output logic      [31:0]                 o_cfg_rdata,
  output logic                             o_cfg_rvalid,
  input  wire logic [NUM_IRQ-1:0]          i_irq,
  input  wire logic                        i_posted_pending,
  output logic                             o_msg_valid,
  input  wire logic                        i_msg_ready,
  output logic      [idc_pkg::INFO_W-1:0]  o_msg_info,
  output logic                             o_msg_passpw,
  output logic      [SW-1:0]               o_msg_src,
  input  wire logic                        i_eoi_valid,
  input  wire logic [SW-1:0]               i_eoi_src
);
  localparam logic [7:0] LAST_IRQ = 8'(NUM_IRQ - 1);
  localparam logic [8:0] DEF_SPAN = 9'(2 * NUM_IRQ);

  logic [63:0]        defr [NUM_IRQ];
  logic [7:0]         idx;
  logic [7:0]         rel;
  logic               idx_def;
  logic [SW-1:0]      sel;
  logic               sel_hi;
  logic               dp_wr;
  logic [NUM_IRQ-1:0] mask_v;
  logic [NUM_IRQ-1:0] request_end_of_interrupt_flag_v;
  logic [NUM_IRQ-1:0] wait_v;
  logic [NUM_IRQ-1:0] passpw_v;
  logic [NUM_IRQ-1:0] lvl;
  logic [NUM_IRQ-1:0] prev_lvl;
  logic [NUM_IRQ-1:0] pending;
  logic [NUM_IRQ-1:0] eligible;
  logic [SW-1:0]      pick;
  logic               any_elig;
  logic               send_now;

  // index byte lives in the header; other header bytes are constants
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      idx <= 8'h00;
    end else if (i_cfg_wr && i_cfg_addr == idc_pkg::OFS_HEADER
                 && i_cfg_be[idc_pkg::BE_INDEX_LANE]) begin
      idx <= i_cfg_wdata[idc_pkg::HDR_IDX_LSB +: 8]; // RULE_04
    end
  end

  assign rel     = idx - idc_pkg::IDX_DEF_BASE;
  assign idx_def = (idx >= idc_pkg::IDX_DEF_BASE) && ({1'b0, rel} < DEF_SPAN); // RULE_08
  assign sel     = rel[SW:1]; // RULE_08
  assign sel_hi  = rel[0]; // RULE_09
  // partial dataport writes are dropped rather than merged
  assign dp_wr   = i_cfg_wr && i_cfg_addr == idc_pkg::OFS_DATAPORT
                   && i_cfg_be == idc_pkg::BE_FULL_DW && idx_def; // RULE_05 RULE_06

  genvar g;
  for (g = 0; g < NUM_IRQ; g++) begin : gen_src
    localparam logic [63:0] PW_BIT = 64'h1 << idc_pkg::B_PASSPW;
    localparam logic [63:0] POL_BIT = 64'h1 << idc_pkg::B_POLARITY;
    localparam logic [63:0] WMASK = (idc_pkg::DEF_WMASK_BASE
                                     | (PASSPW_RO ? 64'h0 : PW_BIT)
                                     | (EXT_SRC[g] ? POL_BIT : 64'h0)); // RULE_14 RULE_19
    localparam logic [63:0] RST_VAL = idc_pkg::DEF_RESET
                                      | ((PASSPW_RO && PASSPW_VAL) ? PW_BIT : 64'h0);

    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        defr[g] <= RST_VAL; // RULE_21 RULE_15 RULE_20
      end else begin
        if (dp_wr && sel == SW'(g)) begin
          if (sel_hi) begin
            defr[g][63:32] <= (defr[g][63:32] & ~WMASK[63:32])
                              | (i_cfg_wdata & WMASK[63:32]); // RULE_09 RULE_12
            if (i_cfg_wdata[idc_pkg::B_WAIT_EOI - idc_pkg::UPPER_LSB]) begin
              defr[g][idc_pkg::B_WAIT_EOI] <= 1'b0; // RULE_11
            end
          end else begin
            defr[g][31:0] <= (defr[g][31:0] & ~WMASK[31:0])
                             | (i_cfg_wdata & WMASK[31:0]); // RULE_15 RULE_18 RULE_19
          end
        end
        if (i_eoi_valid && i_eoi_src == SW'(g)) begin
          defr[g][idc_pkg::B_WAIT_EOI] <= 1'b0; // RULE_10
        end
        // set comes last so a send beats a same-cycle clear
        if (send_now && pick == SW'(g) && defr[g][idc_pkg::B_RQ_EOI]) begin
          defr[g][idc_pkg::B_WAIT_EOI] <= 1'b1; // RULE_10
        end
      end
    end

    assign mask_v[g]   = defr[g][idc_pkg::B_MASK];
    assign request_end_of_interrupt_flag_v[g]  = defr[g][idc_pkg::B_RQ_EOI];
    assign wait_v[g]   = defr[g][idc_pkg::B_WAIT_EOI];
    assign passpw_v[g] = defr[g][idc_pkg::B_PASSPW];
    // internal sources ignore polarity since the bit stays zero
    assign lvl[g]      = i_irq[g] ^ defr[g][idc_pkg::B_POLARITY]; // RULE_19
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      prev_lvl <= '0;
    end else begin
      prev_lvl <= lvl;
    end
  end

  // activation held while masked and sent once the mask is lifted
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (send_now && pick == SW'(i)) begin
          pending[i] <= 1'b0;
        end
        if (lvl[i] && !prev_lvl[i]) begin
          pending[i] <= 1'b1; // RULE_22
        end
      end
    end
  end

  assign eligible = pending & ~mask_v & ~(request_end_of_interrupt_flag_v & wait_v); // RULE_20 RULE_17

  // fixed priority: lowest source number wins
  always_comb begin
    pick     = '0;
    any_elig = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        pick     = SW'(i);
        any_elig = 1'b1;
      end
    end
  end

  // one message in flight; ordered messages stall behind posted writes
  assign send_now = !o_msg_valid && any_elig
                    && (passpw_v[pick] || !i_posted_pending); // RULE_13

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_msg_valid <= 1'b0;
    end else if (send_now) begin
      o_msg_valid <= 1'b1;
    end else if (i_msg_ready) begin
      o_msg_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_msg_info   <= '0;
      o_msg_passpw <= 1'b0;
      o_msg_src    <= '0;
    end else if (send_now) begin
      o_msg_info   <= defr[pick][idc_pkg::INFO_HI:idc_pkg::INFO_LO]; // RULE_22
      o_msg_passpw <= passpw_v[pick]; // RULE_12 RULE_13
      o_msg_src    <= pick;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_cfg_rdata  <= '0;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd) begin
        if (i_cfg_addr == idc_pkg::OFS_HEADER) begin
          o_cfg_rdata <= {idc_pkg::CAP_TYPE_CODE, idx, NEXT_PTR,
                          idc_pkg::CAP_ENTRY_ID}; // RULE_01 RULE_02 RULE_03
        end else if (i_cfg_addr == idc_pkg::OFS_DATAPORT && idx == idc_pkg::IDX_LAST_IRQ) begin
          o_cfg_rdata <= {8'h00, LAST_IRQ, 16'h0000}; // RULE_07
        end else if (i_cfg_addr == idc_pkg::OFS_DATAPORT && idx_def) begin
          o_cfg_rdata <= sel_hi ? defr[sel][63:32] : defr[sel][31:0]; // RULE_09
        end else begin
          o_cfg_rdata <= '0; // RULE_06
        end
      end
    end
  end

  sequence s_hdr_read;
    i_cfg_rd && i_cfg_addr == idc_pkg::OFS_HEADER;
  endsequence

  sequence s_launch;
    send_now;
  endsequence

  cap_id_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_01
    s_hdr_read |=> o_cfg_rdata[idc_pkg::HDR_ID_LSB +: 8] == idc_pkg::CAP_ENTRY_ID)
    else $error("entry_identifier wrong");

  next_ptr_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_02
    s_hdr_read |=> o_cfg_rdata[idc_pkg::HDR_PTR_LSB +: 8] == NEXT_PTR)
    else $error("next pointer wrong");

  cap_type_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_03
    s_hdr_read |=> o_cfg_rdata[idc_pkg::HDR_TYPE_LSB +: 8] == idc_pkg::CAP_TYPE_CODE)
    else $error("capability type wrong");

  index_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_04
    i_cfg_wr && i_cfg_addr == idc_pkg::OFS_HEADER && i_cfg_be[idc_pkg::BE_INDEX_LANE]
    |=> idx == $past(i_cfg_wdata[idc_pkg::HDR_IDX_LSB +: 8]))
    else $error("index byte not stored");

  rsvd_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_06
    i_cfg_rd && i_cfg_addr == idc_pkg::OFS_DATAPORT && !idx_def
    && idx != idc_pkg::IDX_LAST_IRQ |=> o_cfg_rdata == 32'h0000_0000)
    else $error("reserved index not zero");

  last_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_07
    i_cfg_rd && i_cfg_addr == idc_pkg::OFS_DATAPORT && idx == idc_pkg::IDX_LAST_IRQ
    |=> o_cfg_rdata[idc_pkg::LAST_IRQ_LSB +: 8] == LAST_IRQ)
    else $error("last interrupt number wrong");

  wait_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_10
    s_launch ##0 request_end_of_interrupt_flag_v[pick] |=> wait_v[$past(pick)])
    else $error("waiting flag not set on send");

  sw_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_11
    dp_wr && sel_hi && i_cfg_wdata[idc_pkg::B_WAIT_EOI - idc_pkg::UPPER_LSB]
    && !(send_now && pick == sel) |=> !wait_v[$past(sel)])
    else $error("waiting flag not cleared by write");

  ordering_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_13
    $rose(o_msg_valid) && !o_msg_passpw |-> $past(!i_posted_pending))
    else $error("message passed posted writes");

  eoi_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_17
    s_launch |-> !(request_end_of_interrupt_flag_v[pick] && wait_v[pick]))
    else $error("sent while awaiting eoi");

  mask_block_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_20
    s_launch |-> !mask_v[pick])
    else $error("masked source sent");

  reset_value_a: assert property (@(posedge i_sys_clk) // RULE_21
    i_srst |=> defr[0][31:0] == idc_pkg::DEF_RESET[31:0] && !o_msg_valid)
    else $error("definition not at default after reset");

  payload_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_22
    s_launch |=> o_msg_valid && o_msg_src == $past(pick)
    && o_msg_info == $past(defr[pick][idc_pkg::INFO_HI:idc_pkg::INFO_LO]))
    else $error("message payload wrong");

  eoi_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_10
    i_eoi_valid && !(send_now && pick == i_eoi_src) |=> !wait_v[$past(i_eoi_src)])
    else $error("waiting flag not cleared by eoi");

  passpw_copy_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_12
    s_launch |=> o_msg_passpw == $past(passpw_v[pick]))
    else $error("passpw not carried in message");

  msg_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RULE_22
    o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg_info) && $stable(o_msg_src))
    else $error("message changed before accept");
endmodule : idc_block
`default_nettype wire

// file: tb/idc_host_model.sv
// upstream host stand-in: accepts messages after a set stall, returns eoi on request
// assumes the block's valid/ready message port and one-cycle eoi pulse
`timescale 1ns/100ps
`default_nettype none
module idc_host_model #(
  parameter int SW = 2
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_msg_valid,
  input  wire logic [idc_pkg::INFO_W-1:0] i_msg_info,
  input  wire logic                       i_msg_passpw,
  input  wire logic [SW-1:0]              i_msg_src,
  input  wire logic [3:0]                 i_stall,
  output logic                            o_msg_ready,
  output logic                            o_eoi_valid,
  output logic      [SW-1:0]              o_eoi_src
);
  logic [3:0]                 wait_cnt;
  int                         n_msgs = 0;
  logic [idc_pkg::INFO_W-1:0] last_info;
  logic                       last_passpw;
  logic [SW-1:0]              last_src;
  initial begin
    o_eoi_valid = 1'b0;
    o_eoi_src   = '0;
  end
  // slow sink: ready only after the stall count has run
  assign o_msg_ready = i_msg_valid && (wait_cnt >= i_stall);
  always @(posedge i_sys_clk) begin
    if (i_srst || !i_msg_valid || o_msg_ready) wait_cnt <= 4'h0;
    else wait_cnt <= wait_cnt + 4'h1;
  end
  always @(posedge i_sys_clk) begin
    if (i_msg_valid && o_msg_ready) begin
      n_msgs      <= n_msgs + 1;
      last_info   <= i_msg_info;
      last_passpw <= i_msg_passpw;
      last_src    <= i_msg_src;
    end
  end
  task automatic send_eoi(input logic [SW-1:0] src);
    @(posedge i_sys_clk);
    #1;
    o_eoi_valid = 1'b1;
    o_eoi_src   = src;
    @(posedge i_sys_clk);
    #1;
    o_eoi_valid = 1'b0;
    // released source lines do not keep the old value
    o_eoi_src   = ~src;
  endtask : send_eoi
endmodule : idc_host_model
`default_nettype wire

// file: tb/idc_block_tb.sv
// self-checking bench for the interrupt capability block
// assumes the host model stands at the message and eoi ports
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module idc_block_tb;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, posted = 0, rv, mv, mr, ev, pw;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be = 4'h0, stall = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdat, d;
  logic [3:0]  irq = 4'h0;
  logic [1:0]  src, esrc;
  logic [53:0] info;
  int          miscompares = 0, n_checks = 0;
  always #20 clk = ~clk;
  idc_block dut (.i_sys_clk(clk), .i_srst(srst), .i_cfg_addr(addr), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdat), .o_cfg_rvalid(rv),
    .i_irq(irq), .i_posted_pending(posted), .o_msg_valid(mv), .i_msg_ready(mr),
    .o_msg_info(info), .o_msg_passpw(pw), .o_msg_src(src), .i_eoi_valid(ev),
    .i_eoi_src(esrc));
  idc_host_model host (.i_sys_clk(clk), .i_srst(srst), .i_msg_valid(mv), .i_msg_info(info),
    .i_msg_passpw(pw), .i_msg_src(src), .i_stall(stall), .o_msg_ready(mr), .o_eoi_valid(ev),
    .o_eoi_src(esrc));
  task automatic test_done;
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr32(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    tick(1);
    wr = 1'b1; addr = a; be = b; wd = v;
    tick(1);
    wr = 1'b0; wd = ~v;
  endtask : wr32
  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    tick(1);
    rd = 1'b1; addr = a;
    tick(1);
    rd = 1'b0;
    `CHK(rv, 1'b1)
    v = rdat;
  endtask : rd32
  task automatic rdi(input logic [7:0] i, output logic [31:0] v);
    wr32(8'h00, 4'h4, {8'h00, i, 16'h0000});
    rd32(8'h04, v);
  endtask : rdi
  task automatic wri(input logic [7:0] i, input logic [31:0] v);
    wr32(8'h00, 4'h4, {8'h00, i, 16'h0000});
    wr32(8'h04, 4'hF, v);
  endtask : wri
  task automatic wait_msg(input int n);
    for (int k = 0; k < 60 && host.n_msgs < n; k++) tick(1);
    `CHK(host.n_msgs, n)
  endtask : wait_msg
  function automatic logic [53:0] inf(input logic [31:0] hi, input logic [31:0] lo);
    return {hi[23:0], lo[31:2]};
  endfunction : inf
  initial begin
    #160000;
    miscompares++;
    test_done();
  end
  initial begin
    tick(2);
    srst = 1'b0;
    rd32(8'h00, d); `CHK(d, 32'h8000_0008)
    rdi(8'h10, d); `CHK(d, 32'hF800_0001)
    rd32(8'h00, d); `CHK(d, 32'h8010_0008)
    rdi(8'h11, d); `CHK(d, 32'h0000_0000)
    rdi(8'h01, d); `CHK(d, 32'h0003_0000)
    wri(8'h05, 32'hFFFF_FFFF); rdi(8'h05, d); `CHK(d, 32'h0000_0000)
    rd32(8'h08, d); `CHK(d, 32'h0000_0000)
    for (int n = 0; n < 4; n++) begin
      wri(8'(16 + 2 * n), {8'hF8, 8'(n), 16'h3C1D});
      wri(8'(17 + 2 * n), {8'hFF, 8'(n), 16'h1234});
      rdi(8'(16 + 2 * n), d); `CHK(d, {8'hF8, 8'(n), 16'h3C1D})
      rdi(8'(17 + 2 * n), d); `CHK(d, {8'h40, 8'(n), 16'h1234})
    end
    wr32(8'h04, 4'h3, 32'h0000_0000);
    rd32(8'h04, d); `CHK(d, 32'h4003_1234)
    // header write without the index lane leaves the index alone
    wr32(8'h00, 4'hB, 32'h00FF_0000);
    rd32(8'h00, d);
    `CHK(d, 32'h8017_0008)
    // masked and ordered-behind-posted phases before the first message
    wri(8'h11, 32'h0000_0055);
    posted = 1'b1;
    wri(8'h10, 32'hF812_3421);
    irq[0] = 1'b1;
    tick(4); `CHK(host.n_msgs, 0)
    wri(8'h10, 32'hF812_3420);
    tick(4); `CHK(host.n_msgs, 0)
    posted = 1'b0;
    wait_msg(1);
    `CHK(host.last_info, inf(32'h55, 32'hF812_3420))
    `CHK(host.last_passpw, 1'b0)
    `CHK(host.last_src, 2'h0)
    rdi(8'h11, d); `CHK(d, 32'h8000_0055)
    irq[0] = 1'b0;
    tick(2);
    irq[0] = 1'b1;
    tick(4); `CHK(host.n_msgs, 1)
    host.send_eoi(2'h0);
    wait_msg(2);
    rdi(8'h11, d); `CHK(d, 32'h8000_0055)
    wri(8'h11, 32'h8000_0055);
    rdi(8'h11, d); `CHK(d, 32'h0000_0055)
    // active-low source fires on unmask, passes posted traffic, slow sink
    stall = 4'h3;
    posted = 1'b1;
    wri(8'h12, 32'hF800_001E);
    wait_msg(3);
    `CHK(host.last_passpw, 1'b1)
    `CHK(host.last_src, 2'h1)
    `CHK(host.last_info, inf(32'h4001_1234, 32'hF800_001E))
    irq[1] = 1'b1;
    tick(2);
    irq[1] = 1'b0;
    wait_msg(4);
    posted = 1'b0;
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    rdi(8'h12, d); `CHK(d, 32'hF800_0001)
    rdi(8'h13, d); `CHK(d, 32'h0000_0000)
    test_done();
  end
endmodule : idc_block_tb
`default_nettype wire
